// ==== inc/sdram_pkg.sv ====
/*
 Shared constants for the synchronous DRAM device model and its controller:
 command codes, pin field positions, timing counts, controller register map.
 Assumes a single 50 MHz system clock shared by both ends.
*/
package sdram_pkg;
   // ==========================================================
   // link widths
   localparam int BANKS  = 4;
   localparam int ADDR_W = 12;
   localparam int DQ_W   = 16;
   localparam int BYTES  = 2;
   localparam int COL_W  = 8;
   localparam int AP_POS = 10;   // all_banks_select_bit / auto precharge
   // ==========================================================
   // commands as {cs_n, ras_n, cas_n, we_n}
   localparam logic [3:0] CMD_NOP = 4'h7;
   localparam logic [3:0] CMD_ACT = 4'h3;
   localparam logic [3:0] CMD_RD  = 4'h5;
   localparam logic [3:0] CMD_WR  = 4'h4;
   localparam logic [3:0] CMD_PRE = 4'h2;
   localparam logic [3:0] CMD_BST = 4'h6;
   // ==========================================================
   // burst length codes of the mode setting
   localparam logic [2:0] BL_FULL = 3'h7;
   localparam int         PAGE    = 256;
   // ==========================================================
   // timing
   localparam int CLK_NS    = 20;
   localparam int T_RP_NS   = 20;   // row_precharge_time
   localparam int T_WR_NS   = 15;   // write recovery
   localparam int T_REF_MS  = 64;
   localparam int TRP_CYC   = (T_RP_NS + CLK_NS - 1) / CLK_NS;
   localparam int TWR_CYC   = (T_WR_NS + CLK_NS - 1) / CLK_NS + 1;
   localparam int REF_CYC   = T_REF_MS * 1000000 / CLK_NS;
   localparam int CL_DEF    = 2;
   localparam int MASK_CYC  = 2;
   // ==========================================================
   // controller register map and fields
   localparam logic [7:0] REG_CMD    = 8'h00;
   localparam logic [7:0] REG_ADDR   = 8'h04;
   localparam logic [7:0] REG_WDATA  = 8'h08;
   localparam logic [7:0] REG_STATUS = 8'h0c;
   localparam logic [7:0] REG_RDATA  = 8'h10;
   localparam int F_AP   = 3;
   localparam int F_BANK = 4;
   localparam int S_BUSY = 4;
   localparam int S_PD   = 5;
   localparam logic [2:0] OP_ACT = 3'h1;
   localparam logic [2:0] OP_RD  = 3'h2;
   localparam logic [2:0] OP_WR  = 3'h3;
   localparam logic [2:0] OP_PRE = 3'h4;
   localparam logic [2:0] OP_PDE = 3'h5;
   localparam logic [2:0] OP_PDX = 3'h6;
   localparam logic [2:0] OP_BST = 3'h7;
endpackage

// ==== inc/sdram_if.sv ====
/*
 Link between the DRAM device and its controller.
 Assumes both ends share core_clk; the shared data wire is resolved here.
*/
`timescale 1ns/1ps
interface sdram_if;
   import sdram_pkg::*;
   logic              cke;
   logic [3:0]        cmd;
   logic [1:0]        bank_select_lines;
   logic [ADDR_W-1:0] addr;
   logic [BYTES-1:0]  dqm;
   logic [DQ_W-1:0]   ctl_dq_out;
   logic              ctl_dq_oe_b;
   logic [DQ_W-1:0]   dev_dq_out;
   logic [BYTES-1:0]  dev_dq_oe_b;
   logic [DQ_W-1:0]   dq;
   // ==========================================================
   // wire resolution: device byte first, then controller, else low
   always_comb begin
      for (int i = 0; i < BYTES; i++) begin
         if (!dev_dq_oe_b[i])
            dq[i*8 +: 8] = dev_dq_out[i*8 +: 8];
         else if (!ctl_dq_oe_b)
            dq[i*8 +: 8] = ctl_dq_out[i*8 +: 8];
         else
            dq[i*8 +: 8] = 8'h00;
      end
   end
   modport dev (input cke, cmd, bank_select_lines, addr, dqm, dq,
                output dev_dq_out, dev_dq_oe_b);
   modport ctl (output cke, cmd, bank_select_lines, addr, dqm,
                output ctl_dq_out, ctl_dq_oe_b, input dq);
endinterface

// ==== src/sdram_dev.sv ====
/*
 Memory end: banks, precharge, power-down, clock suspend, burst
 read/single write and concurrent auto precharge of a four-bank DRAM.
 Assumes the controller keeps command ordering legal; the mode setting
 arrives on plain inputs and row addresses are not stored (rows alias).
*/
`timescale 1ns/1ps
module sdram_dev
   import sdram_pkg::*;
#(
   parameter int DEPTH = PAGE
) (
   // clock and power-on reset
   input  wire logic       core_clk,
   input  wire logic       rst_b,
   // mode setting
   input  wire logic [2:0] mode_burst_len,
   input  wire logic [1:0] mode_cas_latency,
   input  wire logic       write_burst_mode_bit,
   // status
   output logic            pd_precharge,
   output logic            pd_active,
   output logic            suspended,
   // link
   sdram_if.dev            lnk
);
   import sdram_pkg::*;

   // elaboration check: the column counter covers exactly one page
   if (DEPTH != PAGE) begin : g_bad_depth
      $error("DEPTH must equal one page of columns");
   end

   // ==========================================================
   // state
   typedef struct packed {
      logic [BANKS-1:0]             open;
      logic                         pd;
      logic                         susp;
      logic                         brd;
      logic                         bwr;
      logic [1:0]                   bb;
      logic [COL_W-1:0]             col;
      logic [8:0]                   left;
      logic                         full;
      logic                         bap;
      logic                         rec_on;
      logic [1:0]                   rec_bank;
      logic [3:0]                   rec_cnt;
      logic [2:0]                   pv;
      logic [2:0][DQ_W-1:0]         pdat;
      logic [1:0][BYTES-1:0]        dqmd;
   } dev_st_t;

   dev_st_t             st_r;
   dev_st_t             st_nxt;
   logic [DQ_W-1:0]     mem [BANKS*DEPTH];
   logic                we;
   logic [9:0]          waddr;
   logic [BYTES-1:0]    wmask;
   logic [9:0]          raddr;
   logic                nop;
   logic [8:0]          blen;
   logic [1:0]          cl_idx;
   logic [1:0]          cb;
   logic [COL_W-1:0]    ccol;

   // ==========================================================
   // decode
   assign nop    = lnk.cmd[3] || lnk.cmd == CMD_NOP;
   assign cb     = lnk.bank_select_lines;
   assign ccol   = lnk.addr[COL_W-1:0];
   assign cl_idx = (mode_cas_latency == 2'h3) ? 2'h2 : 2'h1;
   always_comb begin
      unique case (mode_burst_len)
         3'h0:    blen = 9'h001;
         3'h1:    blen = 9'h002;
         3'h2:    blen = 9'h004;
         3'h3:    blen = 9'h008;
         default: blen = 9'h100;
      endcase
   end

   // ==========================================================
   // next state
   always_comb begin
      st_nxt = st_r;
      we     = 1'b0;
      waddr  = {st_r.bb, st_r.col};
      wmask  = ~lnk.dqm;
      raddr  = {st_r.bb, st_r.col};
      // gate low while a burst runs freezes the next edge
      st_nxt.susp = !lnk.cke && (st_r.brd || st_r.bwr) && !st_r.pd;
      if (st_r.pd) begin
         // only the clock gate and a nop are listened to here
         if (lnk.cke && nop)
            st_nxt.pd = 1'b0;
      end else if (st_r.susp) begin
         // frozen edge: inputs ignored, data and counter held
         st_nxt.susp = !lnk.cke;
      end else begin
         st_nxt.pv   = {st_r.pv[1:0], 1'b0};
         st_nxt.pdat = {st_r.pdat[1:0], st_r.pdat[0]};
         st_nxt.dqmd = {st_r.dqmd[0], lnk.dqm};
         // write recovery before a deferred precharge
         if (st_r.rec_on) begin
            st_nxt.rec_cnt = st_r.rec_cnt - 4'h1;
            if (st_r.rec_cnt == 4'h1) begin
               st_nxt.rec_on = 1'b0;
               st_nxt.open[st_r.rec_bank] = 1'b0;
            end
         end
         // burst advance
         if (st_r.brd || st_r.bwr) begin
            if (st_r.brd) begin
               st_nxt.pv[0]   = 1'b1;
               st_nxt.pdat[0] = mem[raddr];
            end else begin
               we = 1'b1;
            end
            st_nxt.col = st_r.col + 8'h01;
            if (!st_r.full) begin
               st_nxt.left = st_r.left - 9'h001;
               if (st_r.left == 9'h001) begin
                  st_nxt.brd = 1'b0;
                  st_nxt.bwr = 1'b0;
                  if (st_r.bap && st_r.brd)
                     st_nxt.open[st_r.bb] = 1'b0;
                  if (st_r.bap && st_r.bwr) begin
                     st_nxt.rec_on   = 1'b1;
                     st_nxt.rec_bank = st_r.bb;
                     st_nxt.rec_cnt  = 4'(TWR_CYC);
                  end
               end
            end
         end
         // commands
         if (!lnk.cke && nop && !st_r.brd && !st_r.bwr) begin
            st_nxt.pd   = 1'b1;
            st_nxt.pv   = 3'h0;
            st_nxt.susp = 1'b0;
         end else if (lnk.cmd == CMD_ACT) begin
            st_nxt.open[cb] = 1'b1;
         end else if (lnk.cmd == CMD_PRE) begin
            if (lnk.addr[AP_POS]) begin
               st_nxt.open = '0;
               st_nxt.brd  = 1'b0;
               st_nxt.bwr  = 1'b0;
            end else begin
               st_nxt.open[cb] = 1'b0;
               if (st_r.bb == cb) begin
                  st_nxt.brd = 1'b0;
                  st_nxt.bwr = 1'b0;
               end
            end
         end else if (lnk.cmd == CMD_BST) begin
            st_nxt.brd = 1'b0;
            st_nxt.bwr = 1'b0;
         end else if (lnk.cmd == CMD_RD || lnk.cmd == CMD_WR) begin
            we = 1'b0;                           // cut write data is dropped
            // auto-precharging access to another bank is cut here
            if ((st_r.brd || st_r.bwr) && st_r.bap && st_r.bb != cb) begin
               if (st_r.brd) begin
                  st_nxt.open[st_r.bb] = 1'b0;
               end else begin
                  if (st_r.rec_on)
                     st_nxt.open[st_r.rec_bank] = 1'b0;
                  st_nxt.rec_on   = 1'b1;
                  st_nxt.rec_bank = st_r.bb;
                  st_nxt.rec_cnt  = 4'(TWR_CYC);
               end
            end
            st_nxt.bb   = cb;
            st_nxt.col  = ccol + 8'h01;
            st_nxt.bap  = lnk.addr[AP_POS];
            st_nxt.full = mode_burst_len == BL_FULL;
            st_nxt.left = blen - 9'h001;
            st_nxt.brd  = 1'b0;
            st_nxt.bwr  = 1'b0;
            if (lnk.cmd == CMD_RD) begin
               // older data keeps flowing out for a latency
               st_nxt.pv[0]   = 1'b1;
               raddr          = {cb, ccol};
               st_nxt.pdat[0] = mem[raddr];
               st_nxt.brd     = blen != 9'h001;
               if (blen == 9'h001 && lnk.addr[AP_POS])
                  st_nxt.open[cb] = 1'b0;
            end else begin
               st_nxt.pv  = 3'h0;
               we         = 1'b1;
               waddr      = {cb, ccol};
               st_nxt.bwr = blen != 9'h001 && !write_burst_mode_bit;
               if ((blen == 9'h001 || write_burst_mode_bit) && lnk.addr[AP_POS]) begin
                  st_nxt.rec_on   = 1'b1;
                  st_nxt.rec_bank = cb;
                  st_nxt.rec_cnt  = 4'(TWR_CYC);
               end
            end
         end
      end
   end

   // ==========================================================
   // registers; no power-on data clear of the array
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end

   // byte-masked write port
   always_ff @(posedge core_clk) begin
      for (int i = 0; i < BYTES; i++) begin
         if (we && wmask[i])
            mem[waddr][i*8 +: 8] <= lnk.dq[i*8 +: 8];
      end
   end

   // ==========================================================
   // outputs
   assign lnk.dev_dq_out = st_r.pdat[cl_idx];
   always_comb begin
      for (int i = 0; i < BYTES; i++)
         lnk.dev_dq_oe_b[i] = st_r.pd || !st_r.pv[cl_idx] || st_r.dqmd[1][i];
   end
   assign pd_precharge = st_r.pd && st_r.open == '0;
   assign pd_active    = st_r.pd && st_r.open != '0;
   assign suspended    = st_r.susp;
endmodule

// ==== src/sdram_ctl.sv ====
/*
 Controller end: takes orders through a small register port and drives the
 DRAM link. Assumes the device shares core_clk and is set to burst length 1
 or to single writes; only the first read word is captured.
*/
`timescale 1ns/1ps
module sdram_ctl
   import sdram_pkg::*;
#(
   parameter int CAS_LAT = CL_DEF,
   parameter int REF_LIM = REF_CYC
) (
   // clock and reset
   input  wire logic        core_clk,
   input  wire logic        rst_b,
   // register port
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic [31:0]      reg_rdata,
   // link
   sdram_if.ctl             lnk
);
   import sdram_pkg::*;

   // elaboration check: the power-down counter is 22 bits wide
   if (CAS_LAT < 2 || CAS_LAT > 3 || REF_LIM < 2 || REF_LIM > 4194305) begin : g_bad_cfg
      $error("unsupported latency or refresh limit");
   end

   // ==========================================================
   // state
   typedef enum logic [1:0] {ST_IDLE, ST_MASK, ST_PD} ctl_state_t;
   typedef struct packed {
      ctl_state_t        fsm;
      logic [BANKS-1:0]  open;
      logic              pend;
      logic [2:0]        op;
      logic              ap;
      logic [1:0]        bank;
      logic [ADDR_W-1:0] addr;
      logic [DQ_W-1:0]   wdata;
      logic [DQ_W-1:0]   rdata;
      logic [3:0]        row_precharge_time;
      logic [3:0]        rd_recent;
      logic [3:0]        cap;
      logic [1:0]        mcnt;
      logic [21:0]       pd_cnt;
      logic              cke;
      logic [3:0]        cmd;
      logic [1:0]        ba;
      logic [ADDR_W-1:0] a;
      logic [BYTES-1:0]  dqm;
      logic              oe_b;
      logic [31:0]       rbus;
   } ctl_st_t;

   ctl_st_t st_r;
   ctl_st_t st_nxt;

   // ==========================================================
   // next state
   always_comb begin
      st_nxt      = st_r;
      st_nxt.cmd  = CMD_NOP;
      st_nxt.oe_b = 1'b1;
      st_nxt.rbus = 32'h0000_0000;
      if (st_r.row_precharge_time != 4'h0)
         st_nxt.row_precharge_time = st_r.row_precharge_time - 4'h1;
      if (st_r.rd_recent != 4'h0)
         st_nxt.rd_recent = st_r.rd_recent - 4'h1;
      if (st_r.cap != 4'h0)
         st_nxt.cap = st_r.cap - 4'h1;
      if (st_r.cap == 4'h1)
         st_nxt.rdata = lnk.dq;
      // register port
      if (reg_wr) begin
         unique case (reg_addr)
            REG_ADDR:  st_nxt.addr  = reg_wdata[ADDR_W-1:0];
            REG_WDATA: st_nxt.wdata = reg_wdata[DQ_W-1:0];
            REG_CMD: begin
               // orders while busy are dropped, except leaving power-down
               if (!st_r.pend && (st_r.fsm == ST_IDLE || reg_wdata[2:0] == OP_PDX)) begin
                  st_nxt.pend = 1'b1;
                  st_nxt.op   = reg_wdata[2:0];
                  st_nxt.ap   = reg_wdata[F_AP];
                  st_nxt.bank = reg_wdata[F_BANK +: 2];
               end
            end
            default: ;
         endcase
      end
      if (reg_rd) begin
         unique case (reg_addr)
            REG_ADDR:   st_nxt.rbus = 32'(st_r.addr);
            REG_WDATA:  st_nxt.rbus = 32'(st_r.wdata);
            REG_RDATA:  st_nxt.rbus = 32'(st_r.rdata);
            REG_STATUS: st_nxt.rbus = {26'h0, st_r.fsm == ST_PD,
                                       st_r.pend || st_r.fsm != ST_IDLE, st_r.open};
            default:    st_nxt.rbus = 32'h0000_0000;
         endcase
      end
      // command sequencing
      unique case (st_r.fsm)
         ST_IDLE: begin
            if (st_r.pend) begin
               st_nxt.ba = st_r.bank;
               st_nxt.a  = st_r.addr;
               unique case (st_r.op)
                  OP_ACT: begin
                     if (st_r.row_precharge_time == 4'h0) begin
                        st_nxt.cmd  = CMD_ACT;
                        st_nxt.open[st_r.bank] = 1'b1;
                        st_nxt.pend = 1'b0;
                     end
                  end
                  OP_RD, OP_WR: begin
                     if (!st_r.open[st_r.bank]) begin
                        // idle bank: open the row first
                        if (st_r.row_precharge_time == 4'h0) begin
                           st_nxt.cmd = CMD_ACT;
                           st_nxt.open[st_r.bank] = 1'b1;
                        end
                     end else if (st_r.op == OP_WR && st_r.rd_recent != 4'h0) begin
                        st_nxt.fsm  = ST_MASK;
                        st_nxt.dqm  = '1;
                        st_nxt.mcnt = 2'(MASK_CYC - 1);
                     end else begin
                        st_nxt.a[AP_POS] = st_r.ap;
                        st_nxt.pend      = 1'b0;
                        st_nxt.dqm       = '0;
                        if (st_r.ap) begin
                           st_nxt.open[st_r.bank] = 1'b0;
                           st_nxt.row_precharge_time = 4'(TRP_CYC + TWR_CYC + 8);
                        end
                        if (st_r.op == OP_RD) begin
                           st_nxt.cmd       = CMD_RD;
                           st_nxt.cap       = 4'(CAS_LAT + 1);
                           st_nxt.rd_recent = 4'(CAS_LAT + 1);
                        end else begin
                           st_nxt.cmd   = CMD_WR;
                           st_nxt.oe_b  = 1'b0;
                        end
                     end
                  end
                  OP_PRE: begin
                     st_nxt.cmd       = CMD_PRE;
                     st_nxt.a[AP_POS] = st_r.ap;
                     if (st_r.ap)
                        st_nxt.open = '0;
                     else
                        st_nxt.open[st_r.bank] = 1'b0;
                     st_nxt.row_precharge_time  = 4'(TRP_CYC);
                     st_nxt.pend = 1'b0;
                  end
                  OP_BST: begin
                     st_nxt.cmd  = CMD_BST;
                     st_nxt.pend = 1'b0;
                  end
                  OP_PDE: begin
                     st_nxt.cke    = 1'b0;
                     st_nxt.fsm    = ST_PD;
                     st_nxt.pd_cnt = '0;
                     st_nxt.pend   = 1'b0;
                  end
                  default: st_nxt.pend = 1'b0;
               endcase
            end
         end
         ST_MASK: begin
            // masks stand two clocks before the write
            if (st_r.mcnt == 2'h0) begin
               st_nxt.fsm = ST_IDLE;
               st_nxt.dqm = '0;
            end else begin
               st_nxt.mcnt = st_r.mcnt - 2'h1;
            end
            st_nxt.rd_recent = 4'h0;
         end
         ST_PD: begin
            st_nxt.pd_cnt = st_r.pd_cnt + 22'h1;
            // leave with nop before the refresh period runs out
            if ((st_r.pend && st_r.op == OP_PDX) || st_r.pd_cnt == 22'(REF_LIM - 2)) begin
               st_nxt.cke  = 1'b1;
               st_nxt.fsm  = ST_IDLE;
               st_nxt.pend = 1'b0;
            end
         end
         default: st_nxt.fsm = ST_IDLE;
      endcase
   end

   // ==========================================================
   // registers
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         st_r      <= '0;
         st_r.cke  <= 1'b1;
         st_r.cmd  <= CMD_NOP;
         st_r.oe_b <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ==========================================================
   // outputs
   assign lnk.cke               = st_r.cke;
   assign lnk.cmd               = st_r.cmd;
   assign lnk.bank_select_lines = st_r.ba;
   assign lnk.addr              = st_r.a;
   assign lnk.dqm               = st_r.dqm;
   assign lnk.ctl_dq_out        = st_r.wdata;
   assign lnk.ctl_dq_oe_b       = st_r.oe_b;
   assign reg_rdata             = st_r.rbus;
endmodule

// ==== verif/sdram_chk.sv ====
/* link assertions for the two DRAM ends.
   assumes one core_clk domain; sits beside the link instance. */
`timescale 1ns/1ps
module sdram_chk
   import sdram_pkg::*;
#(parameter int REF_LIM = REF_CYC) (
   // clock and reset
   input wire logic            core_clk,
   input wire logic            rst_b,
   // link
   input wire logic            cke,
   input wire logic [3:0]      cmd,
   input wire logic [1:0]      dqm,
   input wire logic            ctl_dq_oe_b,
   input wire logic [1:0]      dev_dq_oe_b,
   input wire logic [DQ_W-1:0] dq
);
   int gate_r;
   // ==========================================
   // gated cycle count: refresh is lost while gated
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) gate_r <= 0;
      else gate_r <= cke ? 0 : gate_r + 1;
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   chk_gate_nop: assert property (!cke |-> cmd == CMD_NOP)
      else $error("command beside low gate");
   chk_pd_quiet: assert property (!cke && dev_dq_oe_b == 2'h3 |=> dev_dq_oe_b == 2'h3)
      else $error("output while powered down");
   chk_rd_mask: assert property (cmd == CMD_RD && cke ##1 cke |=> dev_dq_oe_b == $past(dqm, 2))
      else $error("read data lane wrong");
   chk_wr_unmask: assert property (cmd == CMD_WR |-> dqm == 2'h0 && !ctl_dq_oe_b)
      else $error("write masked or undriven");
   chk_no_clash: assert property (!(!ctl_dq_oe_b && dev_dq_oe_b != 2'h3))
      else $error("both ends drive data");
   chk_exit_nop: assert property ($rose(cke) |-> cmd == CMD_NOP)
      else $error("gate raised without nop");
   chk_pre_gap: assert property (cmd == CMD_PRE |=> cmd == CMD_NOP)
      else $error("command right after precharge");
   chk_ref_bound: assert property (gate_r <= REF_LIM)
      else $error("power-down too long");
   cover property (cmd == CMD_RD ##2 dev_dq_oe_b == 2'h0);
   cover property ($fell(cke));
   cover property (cmd == CMD_PRE);
endmodule

// ==== verif/sdram_bank_power_control_tb.sv ====
/* bench for both DRAM ends joined by the link.
   assumes 50 MHz core_clk, device set for burst length 1, then for single writes. */
`timescale 1ns/1ps
module sdram_bank_power_control_tb;
   import sdram_pkg::*;
   logic        core_clk, rst_b, reg_wr, reg_rd, wbm, pd_precharge, pd_active, susp;
   logic [7:0]  reg_addr;
   logic [31:0] reg_wdata, reg_rdata, s, r, seed;
   logic [2:0]  bl;
   logic [3:0]  om;
   logic [15:0] mem [int];
   int          mismatches, compares, cyc;
   sdram_if lnk();
   sdram_dev i_sdram_dev (.core_clk, .rst_b, .mode_burst_len(bl), .mode_cas_latency(2'h2),
      .write_burst_mode_bit(wbm), .pd_precharge, .pd_active, .suspended(susp), .lnk);
   sdram_ctl #(.REF_LIM(50)) i_sdram_ctl (.core_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr,
      .reg_rd, .reg_rdata, .lnk);
   sdram_chk #(.REF_LIM(50)) i_sdram_chk (.core_clk, .rst_b, .cke(lnk.cke), .cmd(lnk.cmd),
      .dqm(lnk.dqm), .ctl_dq_oe_b(lnk.ctl_dq_oe_b), .dev_dq_oe_b(lnk.dev_dq_oe_b), .dq(lnk.dq));
   function automatic logic [31:0] rnd();
      seed ^= seed << 13; seed ^= seed >> 17; seed ^= seed << 5;
      return seed;
   endfunction
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e) begin
         mismatches++;
         $display("wrong value at %0t: %h %h", $time, g, e);
      end
   endtask
   // strobes drop with a gap so no signal is set twice in one step
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1; @(posedge core_clk);
      reg_wr <= 1'b0; @(posedge core_clk);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      reg_addr <= a; reg_rd <= 1'b1; @(posedge core_clk);
      reg_rd <= 1'b0; #1 d = reg_rdata; @(posedge core_clk);
   endtask
   // order alone, no wait: lets two orders follow each other closely
   task automatic go(input logic [2:0] o, input logic ap, input logic [1:0] b);
      wr(REG_CMD, {26'h0, b, ap, o});
   endtask
   // poll busy with a bound; busy drops before read data land, so wait two more
   task automatic idle;
      for (int i = 0; i < 100; i++) begin
         rd(REG_STATUS, s);
         if (!s[S_BUSY]) break;
      end
      chk({31'h0, s[S_BUSY]}, 32'h0);
      repeat (2) @(posedge core_clk);
   endtask
   // level flags sampled off the edge, then back on it
   task automatic lvl(input logic [31:0] e);
      #1 chk({29'h0, susp, pd_active, pd_precharge}, e);
      @(posedge core_clk);
   endtask
   // one order, then wait for it
   task automatic op(input logic [2:0] o, input logic ap, input logic [1:0] b, input logic [7:0] c,
      input logic [15:0] d);
      wr(REG_ADDR, {24'h0, c}); wr(REG_WDATA, {16'h0, d}); go(o, ap, b); idle();
   endtask
   task automatic finish_test;
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 30000) begin
         mismatches++;
         finish_test;
      end
   end
   initial begin
      seed = 32'h4f01; {rst_b, reg_wr, reg_rd, wbm} = 4'h0; bl = 3'h0; om = 4'h0;
      reg_addr = 8'h0; reg_wdata = 32'h0; mismatches = 0; compares = 0; cyc = 0;
      repeat (4) @(posedge core_clk);
      rst_b <= 1'b1;
      rd(REG_STATUS, s); chk(s, 32'h0);
      // random column writes read back through the link
      for (int i = 0; i < 8; i++) begin
         r = rnd(); op(OP_WR, 1'b0, r[9:8], r[7:0], r[31:16]);
         mem[int'(r[9:0])] = r[31:16]; om[r[9:8]] = 1'b1;
         op(OP_RD, 1'b0, r[9:8], r[7:0], 16'h0); rd(REG_RDATA, s);
         chk(s, {16'h0, mem[int'(r[9:0])]});
      end
      rd(REG_STATUS, s); chk(s & 32'hf, {28'h0, om});
      $display("test access done");
      for (int k = 0; k < 4; k++) op(OP_ACT, 1'b0, k[1:0], 8'h0, 16'h0);
      op(OP_PRE, 1'b0, 2'h2, 8'h0, 16'h0); rd(REG_STATUS, s); chk(s & 32'hf, 32'hb);
      go(OP_PDE, 1'b0, 2'h0); repeat (2) @(posedge core_clk); lvl(32'h2);
      op(OP_PDX, 1'b0, 2'h0, 8'h0, 16'h0); lvl(32'h0);
      op(OP_PRE, 1'b1, 2'h1, 8'h0, 16'h0); rd(REG_STATUS, s); chk(s & 32'hf, 32'h0);
      go(OP_PDE, 1'b0, 2'h0); repeat (2) @(posedge core_clk); lvl(32'h1);
      repeat (60) @(posedge core_clk);
      rd(REG_STATUS, s); chk(s[S_PD], 1'b0);
      $display("test power-down done");
      bl <= 3'h2; wbm <= 1'b1;
      op(OP_WR, 1'b0, 2'h0, 8'h10, 16'haaaa); op(OP_WR, 1'b0, 2'h0, 8'h11, 16'h5555);
      op(OP_WR, 1'b0, 2'h0, 8'h10, 16'h1234); op(OP_RD, 1'b0, 2'h0, 8'h11, 16'h0);
      rd(REG_RDATA, s); chk(s, 32'h5555);
      op(OP_WR, 1'b1, 2'h1, 8'h20, 16'hbeef); op(OP_RD, 1'b0, 2'h0, 8'h10, 16'h0);
      rd(REG_RDATA, s); chk(s, 32'h1234);
      rd(REG_STATUS, s); chk(s & 32'hf, 32'h1);
      op(OP_RD, 1'b0, 2'h1, 8'h20, 16'h0); rd(REG_RDATA, s); chk(s, 32'hbeef);
      // gate dropped right behind a read burst: suspend, not power-down
      wr(REG_ADDR, 32'h10); go(OP_RD, 1'b0, 2'h0); go(OP_PDE, 1'b0, 2'h0);
      repeat (2) @(posedge core_clk); lvl(32'h4);
      idle(); lvl(32'h0); rd(REG_RDATA, s); chk(s, 32'h1234);
      // write right behind an auto-precharging read: masks stand two clocks first
      wr(REG_WDATA, 32'hc3c3); go(OP_RD, 1'b1, 2'h0); go(OP_WR, 1'b0, 2'h1); idle();
      rd(REG_RDATA, s); chk(s, 32'h1234);
      rd(REG_STATUS, s); chk(s & 32'hf, 32'h2);
      op(OP_RD, 1'b0, 2'h1, 8'h10, 16'h0); rd(REG_RDATA, s); chk(s, 32'hc3c3);
      rd(8'h3c, s); chk(s, 32'h0);
      $display("test modes done");
      finish_test;
   end
endmodule
